/* File: shared/muldiv_pkg.sv */
// Purpose: shared constants and carriers for the integer multiply/divide datapath
// Assumes: 64-bit general registers, 6-bit function field of the extended opcode group
// Notes: function codes select the operation; the issue logic decodes the major opcode
package muldiv_pkg;

  localparam int XLEN = 64;
  localparam int WORD_W = 32;
  localparam int FUNC_W = 6;
  localparam int REG_IDX_W = 5;

  // ==========================================================
  // function codes of the extended opcode group
  localparam logic [FUNC_W-1:0] FUNC_WORD_SIGNED_MULTIPLY = 6'h10;
  localparam logic [FUNC_W-1:0] FUNC_DWORD_SIGNED_MULTIPLY = 6'h11;
  localparam logic [FUNC_W-1:0] FUNC_WORD_UNSIGNED_MULTIPLY = 6'h12;
  localparam logic [FUNC_W-1:0] FUNC_DWORD_UNSIGNED_MULTIPLY = 6'h13;
  localparam logic [FUNC_W-1:0] FUNC_WORD_SIGNED_DIVIDE = 6'h14;

  // ==========================================================
  // cycle counts and reset values
  localparam int MUL_LATENCY = 1;
  localparam int DIV_STEPS = WORD_W;
  localparam logic [WORD_W-1:0] DIV_BY_ZERO_QUOT = 32'hFFFFFFFF;
  localparam logic [XLEN-1:0] DATA_RESET = 64'h0000000000000000;
  localparam logic [REG_IDX_W-1:0] IDX_RESET = 5'h00;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [FUNC_W-1:0] func;
    logic [REG_IDX_W-1:0] dest;
    logic [XLEN-1:0] src_a;
    logic [XLEN-1:0] src_b;
  } req_t;

  typedef struct packed {
    logic [REG_IDX_W-1:0] dest;
    logic [XLEN-1:0] data;
    logic unsupported;
  } rsp_t;

endpackage

/* File: hdl/word_divider.sv */
// Purpose: iterative signed word divider, one quotient bit per clock
// Assumes: start_i is only raised while busy_o is low
// Notes: quotient truncates toward zero; a zero divisor gives all ones
module word_divider #(
  parameter int W = muldiv_pkg::WORD_W
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic start_i,
  input wire logic [W-1:0] dividend_i,
  input wire logic [W-1:0] divisor_i,
  output logic busy_o,
  output logic done_o,
  output logic [W-1:0] quot_o
);

  localparam int CNT_W = $clog2(W + 1);

  if (W < 2) begin
    $error("word_divider needs W of at least 2");
  end

  logic [W:0] rem_ff, nxt_rem;
  logic [W-1:0] quo_ff, nxt_quo;
  logic [W-1:0] dsr_ff, nxt_dsr;
  logic neg_ff, nxt_neg;
  logic zero_ff, nxt_zero;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic done_ff, nxt_done;
  logic [W-1:0] quot_ff, nxt_quot;

  function automatic logic [W-1:0] magnitude(input logic [W-1:0] v);
    magnitude = v[W-1] ? (~v + 1'b1) : v;
  endfunction

  // ==========================================================
  // restoring step
  always_comb begin
    logic [W:0] shifted;
    logic [W:0] diff;
    logic [W-1:0] q_next;
    shifted = '0;
    diff = '0;
    q_next = '0;
    nxt_rem = rem_ff;
    nxt_quo = quo_ff;
    nxt_dsr = dsr_ff;
    nxt_neg = neg_ff;
    nxt_zero = zero_ff;
    nxt_cnt = cnt_ff;
    nxt_done = 1'b0;
    nxt_quot = quot_ff;
    if (start_i) begin
      nxt_rem = '0;
      nxt_quo = magnitude(dividend_i);
      nxt_dsr = magnitude(divisor_i);
      nxt_neg = dividend_i[W-1] ^ divisor_i[W-1];
      nxt_zero = (divisor_i == '0);
      nxt_cnt = CNT_W'(W);
    end else if (cnt_ff != '0) begin
      shifted = {rem_ff[W-1:0], quo_ff[W-1]};
      diff = shifted - {1'b0, dsr_ff};
      if (!diff[W]) begin
        nxt_rem = diff;
        q_next = {quo_ff[W-2:0], 1'b1};
      end else begin
        nxt_rem = shifted;
        q_next = {quo_ff[W-2:0], 1'b0};
      end
      nxt_quo = q_next;
      nxt_cnt = cnt_ff - 1'b1;
      if (cnt_ff == CNT_W'(1)) begin
        nxt_done = 1'b1;
        // the most negative dividend over -1 wraps silently [RULE6]
        nxt_quot = neg_ff ? (~q_next + 1'b1) : q_next;
        // fixed answer keeps the divide bounded and trap-free [RULE7]
        if (zero_ff) begin
          nxt_quot = muldiv_pkg::DIV_BY_ZERO_QUOT;
        end
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      rem_ff <= '0;
      quo_ff <= '0;
      dsr_ff <= '0;
      neg_ff <= 1'b0;
      zero_ff <= 1'b0;
      cnt_ff <= '0;
      done_ff <= 1'b0;
      quot_ff <= '0;
    end else begin
      rem_ff <= nxt_rem;
      quo_ff <= nxt_quo;
      dsr_ff <= nxt_dsr;
      neg_ff <= nxt_neg;
      zero_ff <= nxt_zero;
      cnt_ff <= nxt_cnt;
      done_ff <= nxt_done;
      quot_ff <= nxt_quot;
    end
  end

  assign busy_o = (cnt_ff != '0) || done_ff;
  assign done_o = done_ff;
  assign quot_o = quot_ff;

endmodule

/* File: hdl/integer_mul_div_unit.sv */
// Purpose: execution datapath for the three-operand integer multiply and divide group
// Assumes: issue logic holds a request until req_ready_o; results are taken when valid
// Notes: multiplies answer in one cycle, the word divide in DIV_STEPS plus two
//
// How it works
// RULE1 - signed word multiply, low word sign-extended
// RULE2 - unsigned word multiply, low word sign-extended
// RULE3 - signed doubleword multiply, keep low 64 bits
// RULE4 - unsigned doubleword multiply, keep low 64 bits
// RULE5 - signed word divide, quotient sign-extended
// RULE6 - no arithmetic exception; overflow silently dropped
// RULE7 - zero divisor completes with fixed value
module integer_mul_div_unit #(
  parameter int XLEN = muldiv_pkg::XLEN,
  parameter int WORD_W = muldiv_pkg::WORD_W
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic req_valid_i,
  input wire muldiv_pkg::req_t req_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output muldiv_pkg::rsp_t rsp_o
);

  // the word slices and the divider width are fixed to this pairing
  if (XLEN != muldiv_pkg::XLEN || WORD_W != muldiv_pkg::WORD_W) begin
    $error("integer_mul_div_unit only serves 64-bit registers with 32-bit words");
  end

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_DIVIDE
  } state_t;

  // ==========================================================
  // operation decode and multiply arithmetic
  function automatic logic is_multiply(input logic [muldiv_pkg::FUNC_W-1:0] f);
    is_multiply = (f == muldiv_pkg::FUNC_WORD_SIGNED_MULTIPLY) ||
                  (f == muldiv_pkg::FUNC_WORD_UNSIGNED_MULTIPLY) ||
                  (f == muldiv_pkg::FUNC_DWORD_SIGNED_MULTIPLY) ||
                  (f == muldiv_pkg::FUNC_DWORD_UNSIGNED_MULTIPLY);
  endfunction

  function automatic logic [XLEN-1:0] sext_word(input logic [WORD_W-1:0] w);
    sext_word = {{(XLEN - WORD_W){w[WORD_W-1]}}, w};
  endfunction

  // operation classes; anything outside the implemented set is answered, never trapped
  typedef enum logic [1:0] {
    OP_MULTIPLY,
    OP_DIVIDE,
    OP_UNKNOWN
  } op_kind_t;

  // one decode shared by the start strobe and the response path
  function automatic op_kind_t classify(input logic [muldiv_pkg::FUNC_W-1:0] f);
    if (is_multiply(f)) begin
      classify = OP_MULTIPLY;
    end else if (f == muldiv_pkg::FUNC_WORD_SIGNED_DIVIDE) begin
      classify = OP_DIVIDE;
    end else begin
      classify = OP_UNKNOWN;
    end
  endfunction

  // operands are widened explicitly so no product is cut or padded by context
  function automatic logic [XLEN-1:0] mul_word_signed(
    input logic [XLEN-1:0] a,
    input logic [XLEN-1:0] b
  );
    logic [XLEN-1:0] p;
    p = sext_word(a[WORD_W-1:0]) * sext_word(b[WORD_W-1:0]);
    mul_word_signed = sext_word(p[WORD_W-1:0]); // [RULE1]
  endfunction

  function automatic logic [XLEN-1:0] mul_word_unsigned(
    input logic [XLEN-1:0] a,
    input logic [XLEN-1:0] b
  );
    logic [XLEN-1:0] p;
    p = {{(XLEN - WORD_W){1'b0}}, a[WORD_W-1:0]} * {{(XLEN - WORD_W){1'b0}}, b[WORD_W-1:0]};
    mul_word_unsigned = sext_word(p[WORD_W-1:0]); // [RULE2]
  endfunction

  function automatic logic [XLEN-1:0] mul_dword_signed(
    input logic [XLEN-1:0] a,
    input logic [XLEN-1:0] b
  );
    logic [2*XLEN-1:0] p;
    p = {{XLEN{a[XLEN-1]}}, a} * {{XLEN{b[XLEN-1]}}, b};
    mul_dword_signed = p[XLEN-1:0]; // [RULE3]
  endfunction

  function automatic logic [XLEN-1:0] mul_dword_unsigned(
    input logic [XLEN-1:0] a,
    input logic [XLEN-1:0] b
  );
    logic [2*XLEN-1:0] p;
    p = {{XLEN{1'b0}}, a} * {{XLEN{1'b0}}, b};
    mul_dword_unsigned = p[XLEN-1:0]; // [RULE4]
  endfunction

  // every product is formed at full width and truncated; nothing traps [RULE6]
  function automatic logic [XLEN-1:0] mul_result(
    input logic [muldiv_pkg::FUNC_W-1:0] f,
    input logic [XLEN-1:0] a,
    input logic [XLEN-1:0] b
  );
    if (f == muldiv_pkg::FUNC_WORD_SIGNED_MULTIPLY) begin
      mul_result = mul_word_signed(a, b); // [RULE1]
    end else if (f == muldiv_pkg::FUNC_WORD_UNSIGNED_MULTIPLY) begin
      mul_result = mul_word_unsigned(a, b); // [RULE2]
    end else if (f == muldiv_pkg::FUNC_DWORD_SIGNED_MULTIPLY) begin
      mul_result = mul_dword_signed(a, b); // [RULE3]
    end else begin
      mul_result = mul_dword_unsigned(a, b); // [RULE4]
    end
  endfunction

  // ==========================================================
  // control and result registers
  state_t state_ff, nxt_state;
  logic valid_ff, nxt_valid;
  muldiv_pkg::rsp_t rsp_ff, nxt_rsp;
  logic [muldiv_pkg::REG_IDX_W-1:0] div_dest_ff, nxt_div_dest;

  logic accept;
  logic div_start;
  logic div_busy;
  logic div_done;
  logic [WORD_W-1:0] div_quot;
  op_kind_t req_kind;

  // divider busy is folded in so a late done can never collide with a new start
  assign req_ready_o = (state_ff == ST_IDLE) && !div_busy;
  assign accept = req_valid_i && req_ready_o;
  assign req_kind = classify(req_i.func);
  assign div_start = accept && (req_kind == OP_DIVIDE); // [RULE5]

  word_divider #(
    .W(WORD_W)
  ) u_divider (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .start_i(div_start),
    .dividend_i(req_i.src_a[WORD_W-1:0]),
    .divisor_i(req_i.src_b[WORD_W-1:0]),
    .busy_o(div_busy),
    .done_o(div_done),
    .quot_o(div_quot)
  );

  // ==========================================================
  // control group: who owns the datapath and where the quotient goes
  always_comb begin
    nxt_state = state_ff;
    nxt_div_dest = div_dest_ff;
    case (state_ff)
      ST_IDLE: begin
        if (div_start) begin
          nxt_state = ST_DIVIDE;
          nxt_div_dest = req_i.dest;
        end
      end
      ST_DIVIDE: begin
        // the divider always counts out, so this state is never left waiting [RULE7]
        if (div_done) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      state_ff <= ST_IDLE;
      div_dest_ff <= muldiv_pkg::IDX_RESET;
    end else begin
      state_ff <= nxt_state;
      div_dest_ff <= nxt_div_dest;
    end
  end

  // ==========================================================
  // response group: one registered pulse per accepted request
  // accept is only possible while idle, so the two branches never meet
  always_comb begin
    nxt_valid = 1'b0;
    nxt_rsp = rsp_ff;
    if ((state_ff == ST_DIVIDE) && div_done) begin
      nxt_valid = 1'b1;
      nxt_rsp.dest = div_dest_ff;
      nxt_rsp.data = sext_word(div_quot); // [RULE5]
      nxt_rsp.unsupported = 1'b0;
    end else if (accept && !div_start) begin
      nxt_valid = 1'b1;
      nxt_rsp.dest = req_i.dest;
      // unknown codes answer zero with a flag rather than a trap [RULE6]
      if (req_kind == OP_MULTIPLY) begin
        nxt_rsp.data = mul_result(req_i.func, req_i.src_a, req_i.src_b);
        nxt_rsp.unsupported = 1'b0;
      end else begin
        nxt_rsp.data = muldiv_pkg::DATA_RESET;
        nxt_rsp.unsupported = 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      valid_ff <= 1'b0;
      rsp_ff.dest <= muldiv_pkg::IDX_RESET;
      rsp_ff.data <= muldiv_pkg::DATA_RESET;
      rsp_ff.unsupported <= 1'b0;
    end else begin
      valid_ff <= nxt_valid;
      rsp_ff <= nxt_rsp;
    end
  end

  assign rsp_valid_o = valid_ff;
  assign rsp_o = rsp_ff;

endmodule

/* File: testbench/integer_mul_div_unit_monitor.sv */
// Purpose: port checks of the multiply/divide unit
// Assumes: results are sign-safe in their low bits
// Notes: expected product tracked per accepted request
module integer_mul_div_unit_monitor (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic req_valid_i,
  input wire muldiv_pkg::req_t req_i,
  input wire logic req_ready_o,
  input wire logic rsp_valid_o,
  input wire muldiv_pkg::rsp_t rsp_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  // ==========
  // helper state
  logic acc, is_div, is_mul, word_ff, nxt_word, zdiv_ff, nxt_zdiv;
  logic [63:0] prod, exp_ff, nxt_exp;
  assign acc = req_valid_i && req_ready_o;
  assign is_div = req_i.func == 6'h14;
  assign is_mul = req_i.func[5:2] == 4'h4;
  assign prod = req_i.src_a * req_i.src_b;
  always_comb begin
    nxt_exp = nrst_i ? exp_ff : 64'h0;
    nxt_word = nrst_i && word_ff;
    nxt_zdiv = nrst_i && zdiv_ff;
    if (acc) begin
      nxt_exp = req_i.func[0] ? prod : {{32{prod[31]}}, prod[31:0]};
      nxt_word = is_div || (is_mul && !req_i.func[0]);
      nxt_zdiv = is_div && req_i.src_b[31:0] == 32'h0;
    end
  end
  always_ff @(posedge clock_i) begin
    exp_ff <= nxt_exp;
    word_ff <= nxt_word;
    zdiv_ff <= nxt_zdiv;
  end
  // ==========
  // properties
  sequence s_mul_acc; acc && is_mul; endsequence
  sequence s_div_acc; acc && is_div; endsequence
  AST_MUL_LAT: assert property (s_mul_acc |=> rsp_valid_o) else $error("late product");
  AST_MUL_DATA: assert property (s_mul_acc |=> rsp_o.data == exp_ff)
    else $error("wrong product");
  AST_NO_EXC: assert property (s_mul_acc |=> !rsp_o.unsupported) else $error("flagged");
  AST_DIV_BUSY: assert property (s_div_acc |=> !req_ready_o [*8]) else $error("ready early");
  AST_DIV_DONE: assert property (s_div_acc |-> ##[33:34] rsp_valid_o) else $error("hung");
  AST_SEXT: assert property (rsp_valid_o && word_ff |-> rsp_o.data[63:32] == {32{rsp_o.data[31]}})
    else $error("not extended");
  AST_ZDIV: assert property (rsp_valid_o && zdiv_ff |-> &rsp_o.data) else $error("zero divisor");
endmodule

bind integer_mul_div_unit integer_mul_div_unit_monitor mon (.clock_i(clock_i), .nrst_i(nrst_i),
  .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
  .rsp_o(rsp_o));

/* File: testbench/issue_model.sv */
// Purpose: issue logic standing in front of the unit
// Assumes: ready depends only on unit state
// Notes: request held until the accepting edge
module issue_model (
  input wire logic clock_i,
  input wire logic req_ready_i,
  output logic req_valid_o,
  output muldiv_pkg::req_t req_o
);
  timeunit 1ns;
  timeprecision 1ns;
  muldiv_pkg::req_t last = '0;
  initial begin
    req_valid_o = 1'b0;
    req_o = '0;
  end
  task automatic send(input muldiv_pkg::req_t r, output bit ok);
    int n;
    n = 0;
    @(negedge clock_i);
    req_valid_o = 1'b1;
    req_o = r;
    last = r;
    #1;
    while (!req_ready_i && n < 100) begin
      @(negedge clock_i);
      #1;
      n++;
    end
    // ready only moves on a rising edge, so this value holds at the accepting edge
    ok = req_ready_i;
    if (!ok) begin
      req_valid_o = 1'b0;
    end
    @(posedge clock_i);
  endtask
  // released operands are inverted so stale values cannot pass
  task automatic idle();
    @(negedge clock_i);
    req_valid_o = 1'b0;
    req_o = ~last;
  endtask
endmodule

/* File: testbench/integer_mul_div_unit_tb.sv */
// Purpose: self-checking bench of the multiply/divide unit
// Assumes: one response per accepted request, in order
// Notes: corner operands first, then random traffic
module integer_mul_div_unit_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic req_valid_i, req_ready_o, rsp_valid_o;
  muldiv_pkg::req_t req_i;
  muldiv_pkg::rsp_t rsp_o, got;
  muldiv_pkg::rsp_t expq[$];
  int error_cnt = 0;
  int total_checks = 0;
  logic [31:0] lfsr = 32'h00016271;
  logic [5:0] funcs [7] = '{6'h10, 6'h11, 6'h12, 6'h13, 6'h14, 6'h15, 6'h3F};
  logic [63:0] ca [4] = '{64'hFFFFFFFF80000000, 64'h8000000000000000, 64'h7FFFFFFFFFFFFFFF, 64'h00000000FFFFFFFF};
  logic [63:0] cb [4] = '{64'hFFFFFFFFFFFFFFFF, 64'h0, 64'h7FFFFFFFFFFFFFFF, 64'hFFFFFFFF00000007};
  always #5 clock_i = ~clock_i;
  integer_mul_div_unit uut (.clock_i(clock_i), .nrst_i(nrst_i), .req_valid_i(req_valid_i), .req_i(req_i),
    .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o));
  issue_model issue (.clock_i(clock_i), .req_ready_i(req_ready_o), .req_valid_o(req_valid_i), .req_o(req_i));
  // ==========
  // expectations
  function automatic logic [63:0] rnd64();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    rnd64[63:32] = lfsr;
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    rnd64[31:0] = lfsr;
  endfunction
  function automatic muldiv_pkg::rsp_t expect_of(input muldiv_pkg::req_t r);
    logic [63:0] p;
    logic signed [31:0] q;
    muldiv_pkg::rsp_t e;
    p = r.src_a * r.src_b;
    e = '{dest: r.dest, data: 64'h0, unsupported: 1'b0};
    case (r.func)
      6'h10, 6'h12: e.data = {{32{p[31]}}, p[31:0]};
      6'h11, 6'h13: e.data = p;
      6'h14: begin
        if (r.src_b[31:0] == 32'h0) q = muldiv_pkg::DIV_BY_ZERO_QUOT;
        else if (r.src_a[31:0] == 32'h80000000 && r.src_b[31:0] == 32'hFFFFFFFF) q = 32'h80000000;
        else q = $signed(r.src_a[31:0]) / $signed(r.src_b[31:0]);
        e.data = {{32{q[31]}}, q};
      end
      default: e.unsupported = 1'b1;
    endcase
    return e;
  endfunction
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] seen);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic issue_op(input logic [5:0] f, input logic [63:0] a, input logic [63:0] b);
    muldiv_pkg::req_t r;
    bit ok;
    r = '{func: f, dest: a[4:0] ^ b[9:5], src_a: a, src_b: b};
    issue.send(r, ok);
    check("accept", 64'h1, 64'(ok));
    if (ok) expq.push_back(expect_of(r));
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========
  // response scoreboard, sampled mid-cycle
  always @(negedge clock_i) begin
    if (nrst_i === 1'b1 && rsp_valid_o === 1'b1) begin
      if (expq.size() == 0) check("extra response", 64'h0, 64'h1);
      else begin
        got = expq.pop_front();
        check("data", got.data, rsp_o.data);
        check("unsupported", 64'(got.unsupported), 64'(rsp_o.unsupported));
        check("dest", 64'(got.dest), 64'(rsp_o.dest));
      end
    end
  end
  initial begin
    #200000;
    error_cnt++;
    finish_test();
  end
  initial begin
    repeat (2) @(negedge clock_i);
    nrst_i = 1'b1;
    foreach (funcs[i]) foreach (ca[j]) issue_op(funcs[i], ca[j], cb[j]);
    repeat (60) begin
      issue_op(funcs[lfsr % 7], rnd64(), lfsr[4] ? rnd64() : (rnd64() & 64'h3));
      if (lfsr[3]) issue.idle();
    end
    issue.idle();
    repeat (40) @(negedge clock_i);
    check("pending", 64'h0, 64'(expq.size()));
    finish_test();
  end
endmodule
